//--- shared/stc_pkg.sv
// Constants, types and pin carrier for the split-transfer host controller.
// Assumes one 50 MHz system clock and a divided shift clock driven out to the memory.
package stc_pkg;

    // Widths of the memory interface.
    localparam int unsigned DATA_W    = 16;
    localparam int unsigned ADDR_W    = 9;
    localparam int unsigned HALF_WORDS = 256;

    // Timing in nanoseconds and derived cycle counts at 50 MHz.
    localparam int unsigned CLK_PERIOD_NS   = 20;
    localparam int unsigned PWRUP_PAUSE_NS  = 200000;
    localparam int unsigned PWRUP_PAUSE_CYC = (PWRUP_PAUSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STS_NS          = 60;
    localparam int unsigned STS_CYC         = (STS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STROBE_NS       = 80;
    localparam int unsigned STROBE_CYC      = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DUMMY_CYCLES    = 8;
    localparam logic [3:0]  DUMMY_CNT       = 4'h8;
    localparam logic [2:0]  SHIFT_DIV_HALF  = 3'h2;

    // Transfer kinds the user may request.
    typedef enum logic [1:0] {
        STC_XFER_READ,
        STC_XFER_MWRITE,
        STC_XFER_SREAD,
        STC_XFER_SWRITE
    } stc_xfer_e;

    // Strobe levels driven to the memory, all active low except the function select.
    typedef struct packed {
        logic rowStrobe_n;
        logic colStrobe_n;
        logic writeStrobe_n;
        logic transfer_output_strobe_n;
        logic special_function_select;
    } stc_strobe_s;

endpackage : stc_pkg

//--- rtl/stc_host.sv
// Host controller that initializes the memory and issues full and split transfers.
// Assumes the memory's serial side is clocked by the shift clock this block drives out.
module stc_host
    import stc_pkg::*;
#(
    parameter int unsigned PAUSE_CYC = PWRUP_PAUSE_CYC
)
(
    // Clock and reset.
    input  wire logic                 ref_clk,
    input  wire logic                 rst_b,
    // User request and status.
    input  wire logic                 xferReq,
    input  wire stc_xfer_e            xferKind,
    input  wire logic [ADDR_W-1:0]    xferRow,
    input  wire logic [ADDR_W-1:0]    xferCol,
    input  wire logic [DATA_W-1:0]    xferMask,
    input  wire logic                 useRefreshInit,
    input  wire logic                 shiftEnable,
    output logic                      xferAck,
    output logic                      initDone,
    output logic                      xferRefused,
    // Memory pins.
    output stc_strobe_s               strobes,
    output logic [ADDR_W-1:0]         memAddr,
    output logic [DATA_W-1:0]         ramDataOut,
    output logic                      ramDataOe,
    output logic                      serial_shift_clock,
    input  wire logic                 active_half_flag
);

    typedef enum logic [3:0] {
        ST_PAUSE, ST_DUMMY_LO, ST_DUMMY_HI, ST_IDLE, ST_ROW, ST_COL, ST_HOLD, ST_END
    } stc_state_e;

    localparam logic [17:0] PAUSE_LAST = 18'(PAUSE_CYC - 1);
    localparam logic [3:0]  STROBE_LAST = 4'(STROBE_CYC - 1);
    localparam logic [3:0]  STS_LAST    = 4'(STS_CYC);

    stc_state_e       state_r;
    logic [17:0]      pauseCnt_r;
    logic [3:0]       dummyCnt_r;
    logic [3:0]       shiftCnt_r;
    logic [3:0]       phaseCnt_r;
    logic [3:0]       stsCnt_r;
    logic [2:0]       divCnt_r;
    logic             shiftClk_r;
    logic             flagSync1_r;
    logic             flagSync2_r;
    logic             flagLast_r;
    logic             readDone_r;
    logic             mwriteDone_r;
    stc_strobe_s      strobes_r;
    stc_xfer_e        kind_r;
    logic             grantOk;
    logic             isSplit;

    // Tells whether a requested kind is a split transfer.
    function automatic logic split_kind(input stc_xfer_e k);
        split_kind = (k == STC_XFER_SREAD) || (k == STC_XFER_SWRITE);
    endfunction : split_kind

    // Two-flop synchroniser for the flag pin; the second flop is compared with a third, delayed copy.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            flagSync1_r <= 1'b0;
            flagSync2_r <= 1'b0;
            flagLast_r  <= 1'b0;
        end
        else
        begin
            flagSync1_r <= active_half_flag;
            flagSync2_r <= flagSync1_r;
            flagLast_r  <= flagSync2_r;
        end
    end

    // Counts from the last flag toggle so split transfers honour the switch delay.
    // switch delay gate
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            stsCnt_r <= 4'h0;
        else if (flagSync2_r != flagLast_r)
            stsCnt_r <= 4'h0;
        else if (stsCnt_r != STS_LAST)
            stsCnt_r <= stsCnt_r + 4'h1;
    end

    // Shift clock divider; runs during dummy shifts and later while enabled.
    // shift clock gated by dummy shifts and shiftEnable
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            divCnt_r   <= 3'h0;
            shiftClk_r <= 1'b0;
            shiftCnt_r <= 4'h0;
        end
        else if ((state_r == ST_DUMMY_LO || state_r == ST_DUMMY_HI) && shiftCnt_r != DUMMY_CNT
                 || initDone && shiftEnable)
        begin
            if (divCnt_r == SHIFT_DIV_HALF - 3'h1)
            begin
                divCnt_r   <= 3'h0;
                shiftClk_r <= ~shiftClk_r;
                if (shiftClk_r && shiftCnt_r != DUMMY_CNT)
                    shiftCnt_r <= shiftCnt_r + 4'h1;
            end
            else
                divCnt_r <= divCnt_r + 3'h1;
        end
    end

    assign serial_shift_clock = shiftClk_r;

    // Split transfers need the matching full transfer first and the delay elapsed.
    always_comb
    begin
        isSplit = split_kind(xferKind);
        grantOk = 1'b1;
        if (xferKind == STC_XFER_SREAD && !readDone_r)
            grantOk = 1'b0;
        if (xferKind == STC_XFER_SWRITE && !mwriteDone_r)
            grantOk = 1'b0;
        if (isSplit && stsCnt_r != STS_LAST)
            grantOk = 1'b0;
    end

    // Main sequencer: power-up pause, dummy cycles, then transfer cycles.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            state_r      <= ST_PAUSE;
            pauseCnt_r   <= 18'h0;
            dummyCnt_r   <= 4'h0;
            phaseCnt_r   <= 4'h0;
            readDone_r   <= 1'b0;
            mwriteDone_r <= 1'b0;
            kind_r       <= STC_XFER_READ;
            memAddr      <= '0;
            ramDataOut   <= '0;
            ramDataOe    <= 1'b0;
            xferAck      <= 1'b0;
            xferRefused  <= 1'b0;
            initDone     <= 1'b0;
            strobes_r    <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        end
        else
        begin
            xferAck     <= 1'b0;
            xferRefused <= 1'b0;
            case (state_r)
                ST_PAUSE:
                begin
                    pauseCnt_r <= pauseCnt_r + 18'h1;
                    if (pauseCnt_r == PAUSE_LAST)
                    begin
                        phaseCnt_r <= 4'h0;
                        state_r    <= ST_DUMMY_LO;
                    end
                end
                ST_DUMMY_LO:
                begin
                    strobes_r.colStrobe_n <= ~useRefreshInit;
                    phaseCnt_r <= phaseCnt_r + 4'h1;
                    // Row falls a cycle late in refresh style so that the column strobe leads it.
                    if (phaseCnt_r == (useRefreshInit ? 4'h1 : 4'h0))
                        strobes_r.rowStrobe_n <= 1'b0;
                    if (phaseCnt_r == STROBE_LAST)
                    begin
                        phaseCnt_r            <= 4'h0;
                        strobes_r.rowStrobe_n <= 1'b1;
                        strobes_r.colStrobe_n <= 1'b1;
                        dummyCnt_r            <= dummyCnt_r + 4'h1;
                        state_r               <= ST_DUMMY_HI;
                    end
                end
                ST_DUMMY_HI:
                begin
                    phaseCnt_r <= phaseCnt_r + 4'h1;
                    if (phaseCnt_r == STROBE_LAST)
                    begin
                        phaseCnt_r <= 4'h0;
                        if (dummyCnt_r != DUMMY_CNT)
                            state_r <= ST_DUMMY_LO;
                        else if (shiftCnt_r == DUMMY_CNT)
                        begin
                            initDone <= 1'b1;
                            state_r  <= ST_IDLE;
                        end
                    end
                end
                ST_IDLE:
                begin
                    // No request is taken in the cycle after a refusal, while the requester releases it.
                    if (xferReq && grantOk && !xferRefused)
                    begin
                        kind_r  <= xferKind;
                        memAddr <= xferRow;
                        strobes_r.colStrobe_n             <= 1'b1;
                        strobes_r.writeStrobe_n           <= (xferKind == STC_XFER_READ
                                                              || xferKind == STC_XFER_SREAD);
                        strobes_r.special_function_select <= isSplit;
                        strobes_r.transfer_output_strobe_n <= 1'b0;
                        ramDataOut <= xferMask;
                        ramDataOe  <= (xferKind == STC_XFER_MWRITE || xferKind == STC_XFER_SWRITE);
                        phaseCnt_r <= 4'h0;
                        state_r    <= ST_ROW;
                    end
                    else if (xferReq && !xferRefused)
                        xferRefused <= 1'b1;
                end
                ST_ROW:
                begin
                    // Row strobe falls one cycle after the codes settle.
                    strobes_r.rowStrobe_n <= 1'b0;
                    phaseCnt_r <= phaseCnt_r + 4'h1;
                    if (phaseCnt_r == 4'h1)
                    begin
                        ramDataOe  <= 1'b0;
                        memAddr    <= xferCol;
                        phaseCnt_r <= 4'h0;
                        state_r    <= ST_COL;
                    end
                end
                ST_COL:
                begin
                    // column top bit left to device
                    strobes_r.colStrobe_n <= 1'b0;
                    phaseCnt_r <= phaseCnt_r + 4'h1;
                    if (phaseCnt_r == STROBE_LAST)
                    begin
                        phaseCnt_r <= 4'h0;
                        state_r    <= ST_HOLD;
                    end
                end
                ST_HOLD:
                begin
                    // Transfer completes on the rising transfer strobe.
                    strobes_r.transfer_output_strobe_n <= 1'b1;
                    strobes_r.rowStrobe_n              <= 1'b1;
                    strobes_r.colStrobe_n              <= 1'b1;
                    strobes_r.writeStrobe_n            <= 1'b1;
                    strobes_r.special_function_select  <= 1'b0;
                    if (kind_r == STC_XFER_READ)
                    begin
                        readDone_r   <= 1'b1;
                        mwriteDone_r <= 1'b0;
                    end
                    if (kind_r == STC_XFER_MWRITE)
                    begin
                        mwriteDone_r <= 1'b1;
                        readDone_r   <= 1'b0;
                    end
                    state_r <= ST_END;
                end
                ST_END:
                begin
                    phaseCnt_r <= phaseCnt_r + 4'h1;
                    // Acknowledge one cycle early so that the request is released before idle samples it.
                    if (phaseCnt_r == STROBE_LAST - 4'h1)
                        xferAck <= 1'b1;
                    if (phaseCnt_r == STROBE_LAST)
                        state_r <= ST_IDLE;
                end
                default:
                    state_r <= ST_PAUSE;
            endcase
        end
    end

    assign strobes = strobes_r;

    a_init_xfer_high: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !initDone |-> strobes.transfer_output_strobe_n) else $error("transfer strobe low during init");

    a_reset_strobes: assert property (@(posedge ref_clk)
        !rst_b |=> strobes.rowStrobe_n && strobes.transfer_output_strobe_n)
        else $error("strobes not high after reset");

    a_pause_quiet: assert property (@(posedge ref_clk) disable iff (!rst_b)
        state_r == ST_PAUSE |-> strobes.rowStrobe_n) else $error("row strobe during pause");

    a_dummy_count: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(initDone) |-> dummyCnt_r == DUMMY_CNT && shiftCnt_r == DUMMY_CNT)
        else $error("init ended early");

    a_sread_order: assert property (@(posedge ref_clk) disable iff (!rst_b)
        state_r == ST_IDLE && xferReq && xferKind == STC_XFER_SREAD && !readDone_r |=> state_r == ST_IDLE)
        else $error("split read before full read");

    a_swrite_order: assert property (@(posedge ref_clk) disable iff (!rst_b)
        state_r == ST_IDLE && xferReq && xferKind == STC_XFER_SWRITE && !mwriteDone_r |=> state_r == ST_IDLE)
        else $error("split write before masked write");

    a_sts_delay: assert property (@(posedge ref_clk) disable iff (!rst_b)
        state_r == ST_IDLE && xferReq && !xferRefused && isSplit && stsCnt_r != STS_LAST |=> xferRefused)
        else $error("split issued inside switch delay");

    sequence s_codes_set;
        state_r == ST_ROW && !strobes.transfer_output_strobe_n && strobes.special_function_select;
    endsequence

    a_split_codes: assert property (@(posedge ref_clk) disable iff (!rst_b)
        s_codes_set ##0 $fell(strobes.rowStrobe_n) |-> strobes.colStrobe_n)
        else $error("column strobe low at split row fall");

    a_mask_drive: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $fell(strobes.rowStrobe_n) && !strobes.writeStrobe_n && initDone |-> ramDataOe)
        else $error("mask not driven at row fall");

endmodule : stc_host

//--- dv/stc_mem_model.sv
// Behavioural model of the split-transfer memory facing the host controller.
// Assumes the host drives all strobes and the shift clock; the bench reads the seen* outputs.
module stc_mem_model
    import stc_pkg::*;
(
    // Host pins.
    input  wire stc_strobe_s       strobes,
    input  wire logic [ADDR_W-1:0] memAddr,
    input  wire logic [DATA_W-1:0] ramDataOut,
    input  wire logic              ramDataOe,
    input  wire logic              serial_shift_clock,
    output logic                   active_half_flag,
    // Observations for the bench.
    output logic [3:0]             seenCode,
    output logic [ADDR_W-1:0]      seenRow,
    output logic [ADDR_W-1:0]      seenCol,
    output logic [DATA_W-1:0]      seenMask,
    output logic                   serialIn,
    output logic                   loadedHalf,
    output int                     rowFalls,
    output int                     cbrFalls,
    output int                     shiftRises,
    output int                     xfers,
    output int                     stsViol
);
    timeunit 1ns;
    timeprecision 100ps;
    realtime tToggle;
    int      shiftCount;

    // Start with the flag low and no history.
    initial
    begin
        active_half_flag = 1'b0;
        serialIn = 1'b0;
        loadedHalf = 1'b0;
        {rowFalls, cbrFalls, shiftRises, xfers, stsViol, shiftCount} = '0;
        tToggle = -1.0e9;
    end

    always @(posedge serial_shift_clock)
    begin
        shiftRises++;
        if (shiftCount == HALF_WORDS - 1)
        begin
            shiftCount = 0;
            active_half_flag = ~active_half_flag;
            tToggle = $realtime;
        end
        else
            shiftCount++;
    end

    // decode at row fall, unrelated to the shift clock.
    always @(negedge strobes.rowStrobe_n)
    begin
        rowFalls++;
        cbrFalls += int'(!strobes.colStrobe_n);
        seenCode = {strobes.colStrobe_n, strobes.writeStrobe_n,
                    strobes.transfer_output_strobe_n, strobes.special_function_select};
        seenRow = memAddr;
        // undriven lines read as the inverse of the last value.
        seenMask = ramDataOe ? ramDataOut : ~ramDataOut;
        if (!strobes.transfer_output_strobe_n && strobes.colStrobe_n)
        begin
            xfers++;
            if (strobes.special_function_select)
            begin
                if ($realtime - tToggle < STS_NS)
                    stsViol++;
                loadedHalf = ~active_half_flag;
            end
            else
                serialIn = !strobes.writeStrobe_n;
        end
    end

    // Column address taken at the column strobe fall inside a row cycle.
    always @(negedge strobes.colStrobe_n)
        if (!strobes.rowStrobe_n)
            seenCol = memAddr;
endmodule : stc_mem_model

//--- dv/stc_host_test.sv
// Self-checking bench for the split-transfer host controller.
// Assumes the memory model answers on the pins; seed 64 makes runs repeatable.
module stc_host_test
    import stc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PAUSE = 20;
    logic              ref_clk = 1'b0, rst_b = 1'b0, xferReq = 1'b0, useRefreshInit = 1'b0, shiftEnable = 1'b0;
    stc_xfer_e         xferKind = STC_XFER_READ;
    logic [ADDR_W-1:0] xferRow = '0, xferCol = '0, memAddr, seenRow, seenCol;
    logic [DATA_W-1:0] xferMask = '0, ramDataOut, seenMask;
    logic              xferAck, initDone, xferRefused, ramDataOe, serial_shift_clock, active_half_flag;
    logic              serialIn, loadedHalf;
    logic [3:0]        seenCode;
    stc_strobe_s       strobes;
    int                rowFalls, cbrFalls, shiftRises, xfers, stsViol;
    int                err_total = 0, n_compared = 0, seed = 64, cyc = 0, relCyc = 0, firstCyc = -1, trgInit = 0;

    always #10 ref_clk = ~ref_clk;

    stc_host #(.PAUSE_CYC(PAUSE)) uut (.ref_clk(ref_clk), .rst_b(rst_b), .xferReq(xferReq), .xferKind(xferKind),
        .xferRow(xferRow), .xferCol(xferCol), .xferMask(xferMask), .useRefreshInit(useRefreshInit),
        .shiftEnable(shiftEnable), .xferAck(xferAck), .initDone(initDone), .xferRefused(xferRefused),
        .strobes(strobes), .memAddr(memAddr), .ramDataOut(ramDataOut), .ramDataOe(ramDataOe),
        .serial_shift_clock(serial_shift_clock), .active_half_flag(active_half_flag));

    stc_mem_model mem (.strobes(strobes), .memAddr(memAddr), .ramDataOut(ramDataOut), .ramDataOe(ramDataOe),
        .serial_shift_clock(serial_shift_clock), .active_half_flag(active_half_flag), .seenCode(seenCode),
        .seenRow(seenRow), .seenCol(seenCol), .seenMask(seenMask), .serialIn(serialIn), .loadedHalf(loadedHalf),
        .rowFalls(rowFalls), .cbrFalls(cbrFalls), .shiftRises(shiftRises), .xfers(xfers), .stsViol(stsViol));

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict

    // Compares a seen value with the expected one.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t %s: seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check

    // Strobe levels expected at row fall: column, write, transfer, function.
    function automatic logic [3:0] exp_code(input stc_xfer_e k);
        return {1'b1, k == STC_XFER_READ || k == STC_XFER_SREAD, 1'b0, k == STC_XFER_SREAD || k == STC_XFER_SWRITE};
    endfunction : exp_code

    // Cycle counting, init monitoring and the hang limit.
    always @(posedge ref_clk)
    begin
        cyc++;
        relCyc = rst_b ? relCyc + 1 : 0;
        if (rst_b && initDone !== 1'b1 && strobes.transfer_output_strobe_n !== 1'b1)
            trgInit++;
        if (cyc == 12000)
        begin
            err_total++;
            $display("[FAIL] %0t run limit reached", $time);
            print_verdict();
        end
    end

    // Notes the cycle of the first row strobe fall after reset.
    always @(negedge strobes.rowStrobe_n)
        if (firstCyc < 0)
            firstCyc = relCyc;

    // Resets the host and checks the start-up sequence on the pins.
    task automatic do_reset(input logic refresh);
        int r0, s0, c0;
        @(posedge ref_clk);
        rst_b <= 1'b0;
        useRefreshInit <= refresh;
        repeat (16) @(posedge ref_clk);
        #1 check({strobes.rowStrobe_n, strobes.transfer_output_strobe_n}, 2'h3, "strobes in reset");
        {r0, s0, c0} = {rowFalls, shiftRises, cbrFalls};
        trgInit = 0;
        firstCyc = -1;
        @(posedge ref_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < PAUSE + 300 && initDone !== 1'b1; i++)
            @(posedge ref_clk);
        check(initDone, 1, "init done");
        check(firstCyc >= PAUSE, 1, "pause before dummies");
        check(rowFalls - r0 >= DUMMY_CYCLES, 1, "dummy row cycles");
        check(shiftRises - s0 >= DUMMY_CYCLES, 1, "dummy shift cycles");
        check(trgInit, 0, "transfer strobe in init");
        if (refresh)
            check(cbrFalls - c0 >= DUMMY_CYCLES, 1, "column-before-row dummies");
        $display("reset test done, refresh %0d", refresh);
    endtask : do_reset

    // One request with random addresses and mask: 0 ack, 1 refused, 2 no answer.
    task automatic do_xfer(input stc_xfer_e k, output int res);
        res = 2;
        @(posedge ref_clk);
        xferKind <= k;
        xferRow <= ADDR_W'($random(seed));
        xferCol <= ADDR_W'($random(seed));
        xferMask <= DATA_W'($random(seed));
        xferReq <= 1'b1;
        for (int i = 0; i < 40 && res == 2; i++)
        begin
            @(posedge ref_clk);
            if (xferAck === 1'b1)
                res = 0;
            else if (xferRefused === 1'b1)
                res = 1;
        end
        xferReq <= 1'b0;
    endtask : do_xfer

    // Main sequence: start-up, table and random transfers, delay test, second start-up.
    initial
    begin
        stc_xfer_e corner[8] = '{STC_XFER_SREAD, STC_XFER_SWRITE, STC_XFER_READ, STC_XFER_SREAD,
                                 STC_XFER_SWRITE, STC_XFER_MWRITE, STC_XFER_SWRITE, STC_XFER_SREAD};
        stc_xfer_e k;
        logic      rdOk, wrOk, refuse, dir0;
        int        res, n0, s0, nRef;
        do_reset(1'b0);
        {rdOk, wrOk} = 2'h0;
        for (int i = 0; i < 24; i++)
        begin
            k = i < 8 ? corner[i] : stc_xfer_e'($random(seed) & 3);
            refuse = (k == STC_XFER_SREAD && !rdOk) || (k == STC_XFER_SWRITE && !wrOk);
            {n0, dir0} = {xfers, serialIn};
            do_xfer(k, res);
            check(res, refuse, "outcome");
            if (refuse)
                check(xfers, n0, "no cycle when refused");
            else
            begin
                check(seenCode, exp_code(k), "codes at row fall");
                check({seenRow, seenCol}, {xferRow, xferCol}, "row and column");
                if (k == STC_XFER_MWRITE || k == STC_XFER_SWRITE)
                    check(seenMask, xferMask, "mask at row fall");
                check(serialIn, k[1] ? dir0 : k == STC_XFER_MWRITE, "serial direction");
            end
            if (k == STC_XFER_READ)
                {rdOk, wrOk} = 2'h2;
            if (k == STC_XFER_MWRITE)
                {rdOk, wrOk} = 2'h1;
        end
        $display("transfer table and random test done");
        shiftEnable <= 1'b1;
        for (int j = 0; j < 2; j++)
        begin
            do_xfer(j ? STC_XFER_MWRITE : STC_XFER_READ, res);
            check(res, 0, "full transfer");
            dir0 = active_half_flag;
            for (int w = 0; w < 1300 && active_half_flag === dir0; w++)
                @(posedge ref_clk);
            res = 1;
            s0 = shiftRises;
            nRef = 0;
            // One more edge so that the first request lands inside the switch delay.
            @(posedge ref_clk);
            for (int t = 0; t < 6 && res == 1; t++)
            begin
                do_xfer(j ? STC_XFER_SWRITE : STC_XFER_SREAD, res);
                nRef += int'(res == 1);
            end
            check(res, 0, "split after flag toggle");
            check(nRef > 0, 1, "split refused inside delay");
            check(loadedHalf, dir0, "idle half reloaded");
            check(shiftRises > s0, 1, "shifting during split");
        end
        shiftEnable <= 1'b0;
        check(stsViol, 0, "delay after flag toggle");
        $display("split delay test done");
        do_reset(1'b1);
        print_verdict();
    end
endmodule : stc_host_test
